// file: hdl/vuf_pkg.sv
// Purpose: shared constants and carriers for the vbi user-data-word formatter
// Assumes: 8-bit ancillary stream, one clock hclk
// Notes:   register map is a small private block reached over AHB-Lite
package vuf_pkg;

   // ---------------------------------------------------------------
   // register map (byte addresses)
   // ---------------------------------------------------------------
   localparam logic [7:0] VUF_OFS_CTRL     = 8'h00;
   localparam logic [7:0] VUF_OFS_STATUS   = 8'h04;
   localparam logic [7:0] VUF_OFS_DID      = 8'h08;
   localparam logic [7:0] VUF_OFS_SDID_VPS = 8'h0C;
   localparam logic [7:0] VUF_OFS_SDID_WSS = 8'h10;
   localparam logic [7:0] VUF_OFS_SDID_CC  = 8'h14;
   localparam logic [7:0] VUF_OFS_COUNT    = 8'h18;

   localparam logic [7:0] VUF_RST_DID      = 8'h40;
   localparam logic [7:0] VUF_RST_SDID_VPS = 8'h01;
   localparam logic [7:0] VUF_RST_SDID_WSS = 8'h02;
   localparam logic [7:0] VUF_RST_SDID_CC  = 8'h03;
   localparam logic [2:0] VUF_RST_CTRL     = 3'h7;

   // ---------------------------------------------------------------
   // packet shape
   // ---------------------------------------------------------------
   localparam logic [7:0] VUF_ADF0      = 8'h00;
   localparam logic [7:0] VUF_ADF1      = 8'hFF;
   localparam logic [7:0] VUF_FILLER    = 8'h80;
   localparam logic [5:0] VUF_CONST_LOW = 6'h00;
   localparam logic [4:0] VUF_VPS_LEN   = 5'd12;
   localparam logic [4:0] VUF_WSS_LEN   = 5'd8;
   localparam logic [4:0] VUF_CC_LEN    = 5'd8;

   typedef enum logic [1:0] {VUF_SVC_VPS, VUF_SVC_WSS, VUF_SVC_CC} vuf_svc_type;

   // sliced vps content, one line
   typedef struct packed {
      logic [7:0] byte5;
      logic [7:0] byte11;
      logic [7:0] byte12;
      logic [7:0] byte13;
      logic [7:0] byte14;
      logic [4:0] biphase_err;   // bit n-1 = sliced byte n
      logic       start_ok;
      logic       complete;
   } vuf_vps_type;

   typedef struct packed {
      logic [13:0] bits;
      logic [13:0] biphase_err;
      logic        start_ok;
      logic        complete;
   } vuf_wss_type;

   typedef struct packed {
      logic [7:0] first;
      logic [7:0] second;
   } vuf_cc_type;

   typedef struct packed {
      logic [7:0] data;
      logic       valid;
      logic       last;
   } vuf_beat_type;

endpackage

// file: hdl/vuf_word_prot.sv
// Purpose: parity protection of one user data word
// Assumes: six payload bits in, eight bits out
// Notes:   purely combinational
`timescale 1ns/1ps
module vuf_word_prot
   import vuf_pkg::*;
(
   input  wire logic [5:0] low6,
   output logic      [7:0] word
);
   wire par = ^low6;
   assign word = {~par, par, low6};
endmodule // vuf_word_prot

// file: hdl/vuf_ahb_regs.sv
// Purpose: AHB-Lite slave for formatter setup and status
// Assumes: single word transfers, zero wait states
// Notes:   unmapped reads give zero, writes there are dropped
`timescale 1ns/1ps
module vuf_ahb_regs
   import vuf_pkg::*;
(
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   output logic      [31:0] hrdata,
   output logic             hreadyout,
   output logic             hresp,
   input  wire logic [3:0]  status_in,
   input  wire logic [15:0] count_in,
   output logic      [2:0]  ctrl_en,
   output logic      [7:0]  did,
   output logic      [7:0]  sdid_vps,
   output logic      [7:0]  sdid_wss,
   output logic      [7:0]  sdid_cc
);
   logic       wr_pend;
   logic [7:0] wr_addr;
   wire        take  = hsel & htrans[1];
   wire [7:0]  a     = haddr[7:0];
   wire [31:0] rd_val = (a == VUF_OFS_CTRL)     ? {29'h0, ctrl_en} :
                        (a == VUF_OFS_STATUS)   ? {28'h0, status_in} :
                        (a == VUF_OFS_DID)      ? {24'h0, did} :
                        (a == VUF_OFS_SDID_VPS) ? {24'h0, sdid_vps} :
                        (a == VUF_OFS_SDID_WSS) ? {24'h0, sdid_wss} :
                        (a == VUF_OFS_SDID_CC)  ? {24'h0, sdid_cc} :
                        (a == VUF_OFS_COUNT)    ? {16'h0, count_in} : 32'h0;
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend <= 1'b0;
         wr_addr <= 8'h00;
         hrdata  <= 32'h0;
      end else begin
         wr_pend <= take & hwrite;
         wr_addr <= a;
         if (take && !hwrite) begin
            hrdata <= rd_val;
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ctrl_en  <= VUF_RST_CTRL;
         did      <= VUF_RST_DID;
         sdid_vps <= VUF_RST_SDID_VPS;
         sdid_wss <= VUF_RST_SDID_WSS;
         sdid_cc  <= VUF_RST_SDID_CC;
      end else if (wr_pend) begin
         if (wr_addr == VUF_OFS_CTRL) begin
            ctrl_en <= hwdata[2:0];
         end else if (wr_addr == VUF_OFS_DID) begin
            did <= hwdata[7:0];
         end else if (wr_addr == VUF_OFS_SDID_VPS) begin
            sdid_vps <= hwdata[7:0];
         end else if (wr_addr == VUF_OFS_SDID_WSS) begin
            sdid_wss <= hwdata[7:0];
         end else if (wr_addr == VUF_OFS_SDID_CC) begin
            sdid_cc <= hwdata[7:0];
         end
      end
   end
endmodule // vuf_ahb_regs

// file: hdl/vuf_formatter.sv
// Purpose: builds VPS, WSS and caption ancillary packets for the 8-bit stream
// Assumes: slicer presents one line of data with a one-cycle strobe per service
// Notes:   one packet at a time; strobes arriving while busy are counted and dropped, except in the cycle the checksum is taken
//
// Function
// - payload bit 6 is even parity of bits 5..0, bit 7 its inverse
// - VPS packet: header, twelve payload bytes in fixed order, checksum
// - VPS byte 1 holds reserved bits of sliced byte 5
// - VPS byte 2 holds sound and rating bits
// - VPS bytes 3 and 4 hold day, month msb, line address id
// - VPS bytes 5 and 6 hold start hour and month low bits
// - VPS bytes 7 and 8 hold start minute and nationality high bits
// - VPS bytes 9 and 10 hold program source and nationality low bits
// - VPS bytes 11 and 12 hold bi-phase error flags and valid flag
// - VPS valid only when start code matched and whole payload sliced
// - erroneous VPS bytes still output data, with their error flag set
// - WSS packet has eight bytes; first aspect ratio, second group-1 error
// - WSS bytes 3 and 4 hold enhanced services and group-2 error
// - WSS byte 5 holds subtitle bits and group-3 error flag
// - WSS byte 6 is constant 80h
// - WSS byte 7 holds reserved bits and group-4 error; byte 8 valid
// - WSS group error set when any bit of that group had bi-phase error
// - WSS valid only when start code matched and whole payload sliced
// - caption packet: four nibble bytes, parity, constant, two fillers, checksum
// - caption parity byte holds first flag in bit 0, second in bit 1
// - caption constant byte is 80h
// - fillers carry 80h
// - checksum is seven-bit sum of id, sdid, count, payload; bit 7 inverted bit 6
// - data count gives four-byte groups in six bits, parity protected
`timescale 1ns/1ps
module vuf_formatter
   import vuf_pkg::*;
(
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   output logic      [31:0] hrdata,
   output logic             hreadyout,
   output logic             hresp,
   input  wire vuf_vps_type vps_in,
   input  wire logic        vps_strobe,
   input  wire vuf_wss_type wss_in,
   input  wire logic        wss_strobe,
   input  wire vuf_cc_type  cc_in,
   input  wire logic        cc_strobe,
   input  wire logic        out_ready,
   output vuf_beat_type     anc_out,
   output logic             busy
);

   // ---------------------------------------------------------------
   // registers
   // ---------------------------------------------------------------
   logic [2:0]  ctrl_en;
   logic [7:0]  did;
   logic [7:0]  sdid_vps;
   logic [7:0]  sdid_wss;
   logic [7:0]  sdid_cc;
   logic [7:0]  pkt_cnt;
   logic [7:0]  drop_cnt;
   logic [3:0]  last_flags;

   vuf_ahb_regs u_regs (
      .hclk      (hclk),
      .hresetn   (hresetn),
      .hsel      (hsel),
      .haddr     (haddr),
      .htrans    (htrans),
      .hwrite    (hwrite),
      .hsize     (hsize),
      .hwdata    (hwdata),
      .hrdata    (hrdata),
      .hreadyout (hreadyout),
      .hresp     (hresp),
      .status_in (last_flags),
      .count_in  ({drop_cnt, pkt_cnt}),
      .ctrl_en   (ctrl_en),
      .did       (did),
      .sdid_vps  (sdid_vps),
      .sdid_wss  (sdid_wss),
      .sdid_cc   (sdid_cc)
   );

   // ---------------------------------------------------------------
   // payload assembly, six low bits per word
   // ---------------------------------------------------------------
   typedef enum {ST_IDLE, ST_ADF0, ST_ADF1, ST_ADF2, ST_DID, ST_SDID, ST_DC,
                 ST_UDW, ST_CS} vuf_state_type;
   vuf_state_type state;
   vuf_state_type next_state;

   logic [5:0]  pay [0:11];
   logic [5:0]  next_pay [0:11];
   logic        next_word_is_const [0:11];
   logic        is_const [0:11];
   logic [4:0]  pay_len;
   logic [4:0]  next_len;
   logic [4:0]  idx;
   logic [7:0]  sdid_lat;
   logic [6:0]  sum;
   vuf_svc_type next_svc;

   wire vps_go = vps_strobe & ctrl_en[0];
   wire wss_go = wss_strobe & ctrl_en[1];
   wire cc_go  = cc_strobe  & ctrl_en[2];
   wire any_go = vps_go | wss_go | cc_go;

   // vps fields
   wire [7:0] b5 = vps_in.byte5;
   wire [7:0] b11 = vps_in.byte11;
   wire [7:0] b12 = vps_in.byte12;
   wire [7:0] b13 = vps_in.byte13;
   wire [7:0] b14 = vps_in.byte14;
   // fresh per line, from the present strobe only
   wire       vps_valid = vps_in.start_ok & vps_in.complete;

   // wss group errors
   wire [3:0] wss_grp_err = {|wss_in.biphase_err[13:11], |wss_in.biphase_err[10:8],
                             |wss_in.biphase_err[7:4], |wss_in.biphase_err[3:0]};
   wire       wss_valid = wss_in.start_ok & wss_in.complete;

   // caption parity flags: odd parity expected, flag set on failure
   wire       cc_par_first  = ~(^cc_in.first);
   wire       cc_par_second = ~(^cc_in.second);

   always_comb begin
      for (int i = 0; i < 12; i++) begin
         next_pay[i] = 6'h00;
         next_word_is_const[i] = 1'b0;
      end
      next_len = VUF_VPS_LEN;
      next_svc = VUF_SVC_VPS;
      if (vps_go) begin
         next_pay[0]  = {2'b00, b5[3:0]};
         next_pay[1]  = {2'b00, b5[7:4]};
         next_pay[2]  = {2'b00, b11[3:0]};
         next_pay[3]  = {2'b00, b11[7:4]};
         next_pay[4]  = {2'b00, b12[3:0]};
         next_pay[5]  = {2'b00, b12[7:4]};
         next_pay[6]  = {2'b00, b13[3:0]};
         next_pay[7]  = {2'b00, b13[7:4]};
         next_pay[8]  = {2'b00, b14[3:0]};
         next_pay[9]  = {2'b00, b14[7:4]};
         next_pay[10] = {2'b00, vps_in.biphase_err[3:0]};
         next_pay[11] = {4'h0, vps_valid, vps_in.biphase_err[4]};
      end else if (wss_go) begin
         next_svc = VUF_SVC_WSS;
         next_len = VUF_WSS_LEN;
         next_pay[0] = {2'b00, wss_in.bits[3:0]};
         next_pay[1] = {5'h00, wss_grp_err[0]};
         next_pay[2] = {2'b00, wss_in.bits[7:4]};
         next_pay[3] = {5'h00, wss_grp_err[1]};
         next_pay[4] = {2'b00, wss_grp_err[2], wss_in.bits[10:8]};
         next_word_is_const[5] = 1'b1;
         next_pay[6] = {2'b00, wss_grp_err[3], wss_in.bits[13:11]};
         next_pay[7] = {5'h00, wss_valid};
      end else begin
         next_svc = VUF_SVC_CC;
         next_len = VUF_CC_LEN;
         next_pay[0] = {2'b00, cc_in.first[3:0]};
         next_pay[1] = {2'b00, cc_in.first[7:4]};
         next_pay[2] = {2'b00, cc_in.second[3:0]};
         next_pay[3] = {2'b00, cc_in.second[7:4]};
         next_pay[4] = {4'h0, cc_par_second, cc_par_first};
         next_word_is_const[5] = 1'b1;
         next_word_is_const[6] = 1'b1;
         next_word_is_const[7] = 1'b1;
      end
   end

   // ---------------------------------------------------------------
   // word protection and checksum
   // ---------------------------------------------------------------
   wire [7:0] udw_word;
   wire [7:0] dc_word;
   wire [5:0] cur_pay = pay[idx[3:0]];

   vuf_word_prot u_udw (
      .low6 (cur_pay),
      .word (udw_word)
   );

   vuf_word_prot u_dc (
      .low6 ({3'h0, pay_len[4:2]}),
      .word (dc_word)
   );

   wire [7:0] udw_byte = is_const[idx[3:0]] ? VUF_FILLER : udw_word;
   wire [6:0] cs_low   = sum;
   wire [7:0] cs_word  = {~cs_low[6], cs_low};

   // ---------------------------------------------------------------
   // sequencer
   // ---------------------------------------------------------------
   // a shown beat is only replaced once taken, so a stalled checksum is never lost
   wire       adv      = !anc_out.valid | out_ready;
   wire       accept   = (state == ST_IDLE) & adv & any_go;
   wire       udw_last = (idx == pay_len - 5'd1);

   always_comb begin
      next_state = state;
      case (state)
         ST_IDLE: begin
            if (any_go) begin
               next_state = ST_ADF0;
            end
         end
         ST_ADF0: next_state = ST_ADF1;
         ST_ADF1: next_state = ST_ADF2;
         ST_ADF2: next_state = ST_DID;
         ST_DID:  next_state = ST_SDID;
         ST_SDID: next_state = ST_DC;
         ST_DC:   next_state = ST_UDW;
         ST_UDW: begin
            if (udw_last) begin
               next_state = ST_CS;
            end
         end
         ST_CS:   next_state = ST_IDLE;
         default: next_state = ST_IDLE;
      endcase
   end

   // byte that leaves in the current state
   wire [7:0] beat_byte = (state == ST_ADF0) ? VUF_ADF0 :
                          (state == ST_DID)  ? did :
                          (state == ST_SDID) ? sdid_lat :
                          (state == ST_DC)   ? dc_word :
                          (state == ST_UDW)  ? udw_byte :
                          (state == ST_CS)   ? cs_word : VUF_ADF1;
   wire       in_pkt    = (state != ST_IDLE);
   wire [6:0] add_term  = (state == ST_DID || state == ST_SDID ||
                           state == ST_DC  || state == ST_UDW) ? beat_byte[6:0] : 7'h00;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state <= ST_IDLE;
         idx   <= 5'd0;
         sum   <= 7'h00;
      end else if (adv) begin
         state <= next_state;
         idx   <= (state == ST_UDW) ? idx + 5'd1 : 5'd0;
         sum   <= (state == ST_IDLE) ? 7'h00 : sum + add_term;
      end
   end

   // capture of one line, fresh on each accepted strobe
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         for (int i = 0; i < 12; i++) begin
            pay[i]      <= 6'h00;
            is_const[i] <= 1'b0;
         end
         pay_len  <= VUF_VPS_LEN;
         sdid_lat <= 8'h00;
      end else if (accept) begin
         for (int i = 0; i < 12; i++) begin
            pay[i]      <= next_pay[i];
            is_const[i] <= next_word_is_const[i];
         end
         pay_len  <= next_len;
         sdid_lat <= (next_svc == VUF_SVC_VPS) ? sdid_vps :
                     (next_svc == VUF_SVC_WSS) ? sdid_wss : sdid_cc;
      end
   end

   // output stage and statistics
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         anc_out    <= '0;
         busy       <= 1'b0;
         pkt_cnt    <= 8'h00;
         drop_cnt   <= 8'h00;
         last_flags <= 4'h0;
      end else begin
         // busy until the last beat has left, not only the sequencer
         busy <= adv ? (next_state != ST_IDLE) || in_pkt : in_pkt || anc_out.valid;
         if (adv) begin
            anc_out.valid <= in_pkt;
            anc_out.data  <= in_pkt ? beat_byte : 8'h00;
            anc_out.last  <= (state == ST_CS);
         end
         if (adv && state == ST_CS) begin
            pkt_cnt <= pkt_cnt + 8'h01;
         end
         if (any_go && !accept) begin
            drop_cnt <= drop_cnt + 8'h01;
         end
         if (accept && vps_go) begin
            last_flags[1:0] <= {vps_valid, |vps_in.biphase_err};
         end else if (accept && wss_go) begin
            last_flags[3:2] <= {wss_valid, |wss_grp_err};
         end
      end
   end

endmodule // vuf_formatter

// file: tb/vuf_formatter_asserts.sv
// Purpose: port assertions for the vbi ancillary packet formatter
// Assumes: one clock hclk, asynchronous active-low hresetn
// Notes:   sees only the top-level ports; bound at the foot of this file
`timescale 1ns/1ps
module vuf_formatter_asserts
   import vuf_pkg::*;
(
   input  wire logic         hclk,
   input  wire logic         hresetn,
   input  wire logic         hreadyout,
   input  wire logic         hresp,
   input  wire vuf_beat_type anc_out,
   input  wire logic         out_ready,
   input  wire logic         busy
);
   // ---------------------------------------------------------------
   // beat position inside the current packet
   // ---------------------------------------------------------------
   logic [4:0] idx;
   wire        take = anc_out.valid && out_ready;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         idx <= 5'h00;
      end else if (take) begin
         idx <= anc_out.last ? 5'h00 : idx + 5'h01;
      end
   end

   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);

   a_bus_okay: assert property (hreadyout && !hresp)
      else $error("bus slave not ready or not okay");
   a_stall_hold: assert property (anc_out.valid && !out_ready |=> $stable(anc_out))
      else $error("stream beat changed while stalled");
   a_start_zero: assert property ($rose(anc_out.valid) |-> anc_out.data == 8'h00 && idx == 5'h00)
      else $error("packet does not open with 00h");
   a_flag_run: assert property (anc_out.valid && idx inside {5'h01, 5'h02} |-> anc_out.data == 8'hFF)
      else $error("flag bytes are not FFh");
   a_word_parity: assert property (anc_out.valid && idx >= 5'h05 |->
      (anc_out.last || anc_out.data[6] == ^anc_out.data[5:0]) &&
      anc_out.data[7] != anc_out.data[6])
      else $error("protected byte has bad parity bits");
   a_count_value: assert property (anc_out.valid && idx == 5'h05 |-> anc_out.data inside {8'h83, 8'h42})
      else $error("data count byte wrong");
   a_last_len: assert property (anc_out.valid && anc_out.last |-> idx == 5'h12 || idx == 5'h0E)
      else $error("packet length wrong");
   a_last_ends: assert property (take && anc_out.last |=> !anc_out.valid)
      else $error("stream continues after checksum");
   a_busy_span: assert property (anc_out.valid |-> busy)
      else $error("beat shown while not busy");
endmodule // vuf_formatter_asserts

bind vuf_formatter vuf_formatter_asserts u_vuf_formatter_asserts (
   .hclk(hclk), .hresetn(hresetn), .hreadyout(hreadyout), .hresp(hresp),
   .anc_out(anc_out), .out_ready(out_ready), .busy(busy));

// file: tb/vuf_stream_sink.sv
// Purpose: downstream receiver model for the ancillary byte stream
// Assumes: a byte is taken at a rising edge with valid and out_ready high
// Notes:   slow mode accepts one cycle in four to exercise stalls
`timescale 1ns/1ps
module vuf_stream_sink
   import vuf_pkg::*;
(
   input  wire logic         hclk,
   input  wire logic         hresetn,
   input  wire vuf_beat_type anc_out,
   input  wire logic         slow,
   output logic              out_ready
);
   logic [7:0] got[$];
   int         pkts = 0;
   logic [1:0] phase;

   // ---------------------------------------------------------------
   // pacing and capture
   // ---------------------------------------------------------------
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         phase <= 2'h0;
      end else begin
         phase <= phase + 2'h1;
      end
   end

   assign out_ready = !slow || (phase == 2'h3);

   // captured raw; filler bytes are kept so their value can be judged
   always @(posedge hclk) begin
      if (hresetn && anc_out.valid && out_ready) begin
         got.push_back(anc_out.data);
         if (anc_out.last) begin
            pkts <= pkts + 1;
         end
      end
   end
endmodule // vuf_stream_sink

// file: tb/vuf_formatter_tb.sv
// Purpose: self-checking bench for the vbi ancillary packet formatter
// Assumes: zero-wait AHB-Lite slave, sink model paces the stream
// Notes:   expected packets are rebuilt here from the slicer inputs
`timescale 1ns/1ps
module vuf_formatter_tb
   import vuf_pkg::*;
;
   logic         hclk, hresetn, hsel, hwrite, slow, out_ready, hreadyout, hresp, busy;
   logic         vps_strobe, wss_strobe, cc_strobe;
   logic [1:0]   htrans;
   logic [2:0]   hsize;
   logic [31:0]  haddr, hwdata, hrdata, rd;
   vuf_vps_type  vps_in;
   vuf_wss_type  wss_in;
   vuf_cc_type   cc_in;
   vuf_beat_type anc_out;
   logic [7:0]   did_now;
   logic [7:0]   pay[$];
   int           bad_count = 0, n_compared = 0, cyc = 0, pk0;

   initial begin
      hclk = 1'b0;
      forever #5 hclk = ~hclk;
   end

   vuf_formatter u_vuf_formatter (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .vps_in(vps_in), .vps_strobe(vps_strobe),
      .wss_in(wss_in), .wss_strobe(wss_strobe), .cc_in(cc_in), .cc_strobe(cc_strobe),
      .out_ready(out_ready), .anc_out(anc_out), .busy(busy));
   vuf_stream_sink u_vuf_stream_sink (.hclk(hclk), .hresetn(hresetn), .anc_out(anc_out),
      .slow(slow), .out_ready(out_ready));

   // ---------------------------------------------------------------
   // shared helpers
   // ---------------------------------------------------------------
   task automatic finish_test;
      if (bad_count == 0 && n_compared > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         bad_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= {24'h000000, a};
      hwrite <= wr;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      rd = hrdata;
   endtask

   task automatic fire(input logic [2:0] which);
      {cc_strobe, wss_strobe, vps_strobe} <= which;
      @(posedge hclk);
      {cc_strobe, wss_strobe, vps_strobe} <= 3'h0;
   endtask

   function automatic logic [7:0] pr(input logic [5:0] x);
      return {~(^x), ^x, x};
   endfunction

   task automatic nib(input logic [7:0] b);
      pay.push_back(pr({2'h0, b[3:0]}));
      pay.push_back(pr({2'h0, b[7:4]}));
   endtask

   // late strobes land mid-packet, where the formatter must drop them
   task automatic expect_pkt(input logic [7:0] sdid, input logic [2:0] which,
                             input logic [2:0] late);
      logic [7:0] e[$];
      logic [6:0] s;
      u_vuf_stream_sink.got.delete();
      pk0 = u_vuf_stream_sink.pkts;
      fire(which);
      if (late != 3'h0) begin
         repeat (3) @(posedge hclk);
         fire(late);
      end
      while (u_vuf_stream_sink.pkts == pk0) @(posedge hclk);
      e = '{8'h00, 8'hFF, 8'hFF, did_now, sdid, pr(6'(pay.size() / 4))};
      foreach (pay[i]) e.push_back(pay[i]);
      s = 7'h00;
      for (int k = 3; k < e.size(); k++) s += e[k][6:0];
      e.push_back({~s[6], s});
      chk(u_vuf_stream_sink.got.size(), e.size());
      foreach (e[i]) chk(u_vuf_stream_sink.got[i], e[i]);
      pay.delete();
   endtask

   // ---------------------------------------------------------------
   // scenarios
   // ---------------------------------------------------------------
   task automatic t_regs;
      bus(1'b0, VUF_OFS_CTRL, 32'h0);
      chk(rd, {29'h0, VUF_RST_CTRL});
      bus(1'b0, VUF_OFS_SDID_CC, 32'h0);
      chk(rd, {24'h0, VUF_RST_SDID_CC});
      bus(1'b1, 8'h40, 32'hFFFFFFFF);
      bus(1'b0, 8'h40, 32'h0);
      chk(rd, 32'h0);
      bus(1'b1, VUF_OFS_DID, 32'h0000005A);
      bus(1'b0, VUF_OFS_DID, 32'h0);
      chk(rd, 32'h0000005A);
      did_now = 8'h5A;
   endtask

   task automatic t_vps(input logic [7:0] d, input logic ok, input logic [4:0] err);
      vps_in <= '{d, d + 8'h25, d + 8'h4A, d + 8'h6F, d + 8'h94, err, ok, 1'b1};
      for (int k = 0; k < 5; k++) nib(d + 8'(k * 8'h25));
      pay.push_back(pr({2'h0, err[3:0]}));
      pay.push_back(pr({4'h0, ok, err[4]}));
      expect_pkt(VUF_RST_SDID_VPS, 3'h1, 3'h0);
      bus(1'b0, VUF_OFS_STATUS, 32'h0);
      chk(rd[1:0], {ok, |err});
   endtask

   task automatic t_wss(input logic [13:0] b, input logic [13:0] e, input logic c);
      wss_in <= '{b, e, 1'b1, c};
      pay.push_back(pr({2'h0, b[3:0]}));
      pay.push_back(pr({5'h0, |e[3:0]}));
      pay.push_back(pr({2'h0, b[7:4]}));
      pay.push_back(pr({5'h0, |e[7:4]}));
      pay.push_back(pr({2'h0, |e[10:8], b[10:8]}));
      pay.push_back(8'h80);
      pay.push_back(pr({2'h0, |e[13:11], b[13:11]}));
      pay.push_back(pr({5'h0, c}));
      expect_pkt(VUF_RST_SDID_WSS, 3'h2, 3'h0);
      bus(1'b0, VUF_OFS_STATUS, 32'h0);
      chk(rd[3:2], {c, |e});
   endtask

   task automatic t_cc(input logic [7:0] a, input logic [7:0] b);
      cc_in <= '{a, b};
      nib(a);
      nib(b);
      pay.push_back(pr({4'h0, ~^b, ~^a}));
      repeat (3) pay.push_back(8'h80);
      expect_pkt(VUF_RST_SDID_CC, 3'h4, 3'h0);
   endtask

   task automatic t_drop;
      logic [31:0] c0;
      bus(1'b1, VUF_OFS_CTRL, 32'h6);
      pk0 = u_vuf_stream_sink.pkts;
      fire(3'h1);
      repeat (20) @(posedge hclk);
      chk(u_vuf_stream_sink.pkts, pk0);
      bus(1'b1, VUF_OFS_CTRL, 32'h7);
      bus(1'b0, VUF_OFS_COUNT, 32'h0);
      c0 = rd;
      vps_in <= '{8'h12, 8'h36, 8'h5A, 8'h7E, 8'hA2, 5'h00, 1'b1, 1'b0};
      for (int k = 1; k < 10; k += 2) nib(8'(k * 8'h12));
      pay.push_back(pr(6'h00));
      pay.push_back(pr(6'h00));
      expect_pkt(VUF_RST_SDID_VPS, 3'h3, 3'h4);
      repeat (20) @(posedge hclk);
      chk(u_vuf_stream_sink.pkts, pk0 + 1);
      bus(1'b0, VUF_OFS_COUNT, 32'h0);
      chk(rd[15:8], c0[15:8] + 8'h01);
      chk(rd[7:0], c0[7:0] + 8'h01);
   endtask

   // ---------------------------------------------------------------
   // main sequence and hang guard
   // ---------------------------------------------------------------
   initial begin
      hresetn = 1'b0;
      {hsel, hwrite, vps_strobe, wss_strobe, cc_strobe, slow} = 6'h00;
      htrans = 2'h0;
      hsize = 3'h2;
      haddr = 32'h0;
      hwdata = 32'h0;
      vps_in = '0;
      wss_in = '0;
      cc_in = '0;
      did_now = VUF_RST_DID;
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      t_regs;
      slow <= 1'b1;
      t_vps(8'hA3, 1'b1, 5'h15);
      slow <= 1'b0;
      t_vps(8'h3C, 1'b0, 5'h00);
      t_wss(14'h2A5C, 14'h0811, 1'b1);
      t_wss(14'h15A3, 14'h0000, 1'b0);
      t_cc(8'h91, 8'h33);
      t_drop;
      finish_test;
   end

   always @(posedge hclk) begin
      cyc++;
      if (cyc == 20000) begin
         bad_count++;
         finish_test;
      end
   end
endmodule // vuf_formatter_tb
